// ---- verilog/keying_pkg.sv ----
// Constants, register map and carrier types for the site keying and path select block
// Notes on behaviour
// - Either keying input active drives the merged active-low keying request low.
// - Merged request active asserts the transmitter keying output; nothing else.
// - Locally caused keying drops only after both keying inputs go inactive.
// - Host keying command over the link asserts the transmitter keying output.
// - Host keying ends on release command or after thirty minutes, whichever first.
// - Jumper picks external or internal coded-voice detect as the detect source.
// - Coded-voice detect output follows the selected detect and steers output stage.
// - Detect active: balanced output carries only the coded-voice path.
// - Detect inactive: balanced output carries clear audio plus tone data.
// - Noise filter in while control-channel flag inactive, out while active.
// - Control-channel flag active with site keying inactive forces filter out.
// - Serial link is one shared half-duplex pair; one driver at a time.
// - Jumper picks keying logic or controller output as noise filter source.
package keying_pkg;

    // ==========================================================
    // Register map (byte addresses)
    localparam logic [11:0] CTRL_OFS   = 12'h000;
    localparam logic [11:0] STATUS_OFS = 12'h004;
    localparam logic [11:0] CMD_OFS    = 12'h008;
    localparam logic [11:0] TIMER_OFS  = 12'h00C;

    // Control register fields and reset value
    localparam int          CTRL_FILTER_BIT   = 0;
    localparam int          CTRL_LINK_DRV_BIT = 1;
    localparam int          CTRL_LINK_TX_BIT  = 2;
    localparam logic [31:0] CTRL_RESET        = 32'h0000_0000;

    // Command register fields
    localparam int CMD_KEY_BIT     = 0;
    localparam int CMD_RELEASE_BIT = 1;

    // ==========================================================
    // Timing
    localparam longint CLK_HZ          = 250_000_000;
    localparam longint TIMEOUT_MINUTES = 30;
    localparam int     TIMER_W         = 40;
    localparam logic [TIMER_W-1:0] TIMEOUT_CYCLES =
        TIMER_W'(TIMEOUT_MINUTES * 60 * CLK_HZ);

    // ==========================================================
    // Carrier types
    typedef struct packed {
        logic wide_area_keying_in_n;
        logic site_controller_keying_in_n;
        logic coded_voice_detect_in;
        logic internal_detect_in;
        logic control_channel_flag_in;
        logic detect_source_jumper;
        logic noise_filter_source_jumper;
        logic link_rx;
    } pin_in_t;

    localparam int PIN_W = $bits(pin_in_t);
    localparam logic [PIN_W-1:0] PIN_RESET = 8'hC0;

    typedef struct packed {
        logic [22:0] zero;
        logic        link_rx;
        logic        control_channel_flag;
        logic        noise_filter_insert;
        logic        coded_voice_detect;
        logic        keying_out;
        logic        host_keying;
        logic        timed_out;
        logic        local_keying;
        logic        merged_keying_req_n;
    } status_t;

endpackage

// ---- verilog/site_keying_path_select.sv ----
// Keying merge, host keying with timeout, detect path steering and noise filter control
//
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/1ns
module site_keying_path_select #(
    parameter logic [keying_pkg::TIMER_W-1:0] TIMEOUT_CYCLES = keying_pkg::TIMEOUT_CYCLES
) (
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                rst,
    // APB slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    // Site pins, asynchronous
    input  wire keying_pkg::pin_in_t pins,
    // Base station and output stage
    output logic                     transmitter_keying_out,
    output logic                     merged_keying_req_n,
    output logic                     coded_voice_detect_out,
    output logic                     coded_path_select,
    output logic                     clear_sum_select,
    output logic                     noise_filter_insert,
    // Shared half-duplex link driver
    output logic                     link_tx,
    output logic                     link_tx_oe
);

    // ==========================================================
    // Pin synchronisers
    logic [keying_pkg::PIN_W-1:0] sync1_r;
    logic [keying_pkg::PIN_W-1:0] sync2_r;
    logic [keying_pkg::PIN_W-1:0] sync3_r;
    logic [keying_pkg::PIN_W-1:0] filt_r;
    keying_pkg::pin_in_t          pin_f;

    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_r <= keying_pkg::PIN_RESET;
            sync2_r <= keying_pkg::PIN_RESET;
            sync3_r <= keying_pkg::PIN_RESET;
        end else begin
            sync1_r <= pins;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    // Accept a new level only once two stages agree, rejecting single-cycle glitches
    always_ff @(posedge clk) begin
        if (rst) begin
            filt_r <= keying_pkg::PIN_RESET;
        end else begin
            filt_r <= (sync2_r & ~(sync2_r ^ sync3_r)) | (filt_r & (sync2_r ^ sync3_r));
        end
    end

    assign pin_f = filt_r;

    // ==========================================================
    // APB decode
    logic                              setup;
    logic                              wr_en;
    logic [31:0]                       ctrl_r;
    logic                              host_keying_r;
    logic                              timed_out_r;
    logic [keying_pkg::TIMER_W-1:0]    timer_r;
    logic                              keying_out_r;
    logic                              detect_out_r;
    logic                              filter_r;
    logic                              local_req;
    logic                              merged_n;
    logic                              key_cmd;
    logic                              release_cmd;
    logic                              timeout_hit;
    keying_pkg::status_t               status;

    function automatic logic mapped(input logic [11:0] a);
        mapped = (a == keying_pkg::CTRL_OFS) || (a == keying_pkg::STATUS_OFS) ||
                 (a == keying_pkg::CMD_OFS)  || (a == keying_pkg::TIMER_OFS);
    endfunction

    assign setup  = psel && !penable;
    assign wr_en  = psel && penable && pwrite && mapped(paddr);
    assign pready = 1'b1;

    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_r <= keying_pkg::CTRL_RESET;
        end else if (wr_en && paddr == keying_pkg::CTRL_OFS) begin
            ctrl_r <= pwdata & 32'h0000_0007;
        end
    end

    assign key_cmd     = wr_en && paddr == keying_pkg::CMD_OFS &&
                         pwdata[keying_pkg::CMD_KEY_BIT];
    assign release_cmd = wr_en && paddr == keying_pkg::CMD_OFS &&
                         pwdata[keying_pkg::CMD_RELEASE_BIT];

    // Read data captured in setup so it is a flop output during access
    always_ff @(posedge clk) begin
        if (rst) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (setup) begin
            pslverr <= !mapped(paddr);
            if (pwrite) begin
                prdata <= 32'h0000_0000;
            end else if (paddr == keying_pkg::CTRL_OFS) begin
                prdata <= ctrl_r;
            end else if (paddr == keying_pkg::STATUS_OFS) begin
                prdata <= status;
            end else if (paddr == keying_pkg::TIMER_OFS) begin
                prdata <= timer_r[31:0];
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // ==========================================================
    // Keying
    assign local_req = !pin_f.wide_area_keying_in_n || !pin_f.site_controller_keying_in_n;
    assign merged_n  = !local_req;

    // Key wins over release or timeout in the same cycle, so a fresh command is never lost
    always_ff @(posedge clk) begin
        if (rst) begin
            host_keying_r <= 1'b0;
        end else if (key_cmd) begin
            host_keying_r <= 1'b1;
        end else if (release_cmd || timeout_hit) begin
            host_keying_r <= 1'b0;
        end
    end

    assign timeout_hit = host_keying_r && (timer_r >= TIMEOUT_CYCLES - 1'b1);

    always_ff @(posedge clk) begin
        if (rst) begin
            timer_r <= '0;
        end else if (key_cmd || release_cmd || !host_keying_r) begin
            timer_r <= '0;
        end else if (!timeout_hit) begin
            timer_r <= timer_r + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            timed_out_r <= 1'b0;
        end else if (key_cmd) begin
            timed_out_r <= 1'b0;
        end else if (timeout_hit && !release_cmd) begin
            timed_out_r <= 1'b1;
        end
    end

    // Held while any source still wants it
    always_ff @(posedge clk) begin
        if (rst) begin
            keying_out_r <= 1'b0;
        end else begin
            keying_out_r <= !merged_n || host_keying_r;
        end
    end

    // ==========================================================
    // Detect steering and noise filter
    always_ff @(posedge clk) begin
        if (rst) begin
            detect_out_r <= 1'b0;
        end else begin
            detect_out_r <= pin_f.detect_source_jumper ?
                            pin_f.internal_detect_in : pin_f.coded_voice_detect_in;
        end
    end

    // With the jumper on the keying logic, flag active pulls the filter out; site keying only marks a failed controller
    always_ff @(posedge clk) begin
        if (rst) begin
            filter_r <= 1'b1;
        end else if (pin_f.noise_filter_source_jumper) begin
            filter_r <= ctrl_r[keying_pkg::CTRL_FILTER_BIT];
        end else begin
            filter_r <= !pin_f.control_channel_flag_in;
        end
    end

    assign status = '{zero: 23'h00_0000,
                      link_rx: pin_f.link_rx,
                      control_channel_flag: pin_f.control_channel_flag_in,
                      noise_filter_insert: filter_r,
                      coded_voice_detect: detect_out_r,
                      keying_out: keying_out_r,
                      host_keying: host_keying_r,
                      timed_out: timed_out_r,
                      local_keying: local_req,
                      merged_keying_req_n: merged_n};

    // ==========================================================
    // Outputs
    assign transmitter_keying_out = keying_out_r;
    assign merged_keying_req_n    = merged_n;
    assign coded_voice_detect_out = detect_out_r;
    assign coded_path_select      = detect_out_r;
    assign clear_sum_select       = !detect_out_r;
    assign noise_filter_insert    = filter_r;
    assign link_tx                = ctrl_r[keying_pkg::CTRL_LINK_TX_BIT];
    // Driver only on when software takes the pair, leaving it free for the others
    assign link_tx_oe             = ctrl_r[keying_pkg::CTRL_LINK_DRV_BIT];

    // ==========================================================
    // Assertions
    property p_merge;
        @(posedge clk) disable iff (rst)
        merged_n == (pin_f.wide_area_keying_in_n && pin_f.site_controller_keying_in_n);
    endproperty
    a_merge: assert property (p_merge) else $error("merged request wrong");

    property p_local_keys;
        @(posedge clk) disable iff (rst)
        !merged_n |=> transmitter_keying_out;
    endproperty
    a_local_keys: assert property (p_local_keys) else $error("local request not keyed");

    property p_release_local;
        @(posedge clk) disable iff (rst)
        $fell(transmitter_keying_out) |-> $past(merged_n) && !$past(host_keying_r);
    endproperty
    a_release_local: assert property (p_release_local) else $error("early release");

    property p_host_key;
        @(posedge clk) disable iff (rst)
        key_cmd |=> host_keying_r ##1 transmitter_keying_out;
    endproperty
    a_host_key: assert property (p_host_key) else $error("host key ignored");

    property p_host_release;
        @(posedge clk) disable iff (rst)
        (release_cmd && !key_cmd) |=> !host_keying_r && timer_r == '0;
    endproperty
    a_host_release: assert property (p_host_release) else $error("release missed");

    property p_timeout_bound;
        @(posedge clk) disable iff (rst)
        timer_r < TIMEOUT_CYCLES;
    endproperty
    a_timeout_bound: assert property (p_timeout_bound) else $error("timer overran");

    property p_detect_follow;
        @(posedge clk) disable iff (rst)
        $changed(pin_f.coded_voice_detect_in) && !pin_f.detect_source_jumper &&
        $stable(pin_f.detect_source_jumper)
        |=> coded_voice_detect_out == $past(pin_f.coded_voice_detect_in);
    endproperty
    a_detect_follow: assert property (p_detect_follow) else $error("detect lost");

    property p_path_exclusive;
        @(posedge clk) disable iff (rst)
        coded_path_select != clear_sum_select;
    endproperty
    a_path_exclusive: assert property (p_path_exclusive) else $error("paths overlap");

    property p_filter_out;
        @(posedge clk) disable iff (rst)
        pin_f.control_channel_flag_in && !pin_f.noise_filter_source_jumper
        |=> !noise_filter_insert;
    endproperty
    a_filter_out: assert property (p_filter_out) else $error("filter left in");

endmodule

// ---- tb/site_partner.sv ----
// Far side model: site keying pins, detect sources and the shared serial pair
`timescale 1ns/1ns
module site_partner (
    // Levels set by the bench: wa_n, sc_n, dd_ext, dd_int, ccf, det jumper, filter jumper
    input  wire logic [6:0]     lv,
    // Host side of the pair
    input  wire logic           host_drv,
    input  wire logic           host_bit,
    // Block side of the pair
    input  wire logic           link_tx,
    input  wire logic           link_tx_oe,
    // Pins into the block
    output keying_pkg::pin_in_t pins
);
    logic wire_lvl;

    // ==========================================================
    // Pair level
    // Host yields while the block drives; an undriven pair sits at its idle bias, high
    assign wire_lvl = link_tx_oe ? link_tx : (host_drv ? host_bit : 1'b1);
    assign pins     = {lv, wire_lvl};
endmodule

// ---- tb/tb_top.sv ----
// Self-checking bench for keying merge, host keying, detect steering and noise filter
`timescale 1ns/1ns
module tb_top;
    localparam int                             TO   = 50;
    localparam logic [keying_pkg::TIMER_W-1:0] TO_P = keying_pkg::TIMER_W'(TO);
    logic                clk     = 1'b0;
    logic                rst     = 1'b1;
    logic                psel    = 1'b0;
    logic                penable = 1'b0;
    logic                pwrite  = 1'b0;
    logic [11:0]         paddr   = 12'h000;
    logic [31:0]         pwdata  = 32'h0000_0000;
    logic [6:0]          lv      = 7'h60;
    logic                hdrv    = 1'b0;
    logic                hbit    = 1'b0;
    logic [2:0]          ctrl    = 3'h0;
    logic                to_f    = 1'b0;
    logic [31:0]         prdata;
    logic                pready, pslverr, key_o, mrg_n, det_o, cps, css, nfi, ltx, loe;
    keying_pkg::pin_in_t pins;
    logic [32:0]         expq[$];
    int                  err_count = 0;
    int                  n_tests   = 0;
    int                  seed      = 32'hfc50_003c;
    int                  n;
    logic [31:0]         v;

    always #2 clk = ~clk;

    site_keying_path_select #(.TIMEOUT_CYCLES(TO_P)) u_site_keying_path_select (
        .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pins(pins), .transmitter_keying_out(key_o),
        .merged_keying_req_n(mrg_n), .coded_voice_detect_out(det_o),
        .coded_path_select(cps), .clear_sum_select(css),
        .noise_filter_insert(nfi), .link_tx(ltx), .link_tx_oe(loe));

    site_partner u_site_partner (.lv(lv), .host_drv(hdrv), .host_bit(hbit),
        .link_tx(ltx), .link_tx_oe(loe), .pins(pins));

    // ==========================================================
    // Checking and closing
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic end_sim;
        $display("%0d comparisons, %0d mismatches", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Read results are matched in order against the notes the driver left
    always @(posedge clk) begin : mon
        logic [32:0] e;
        if (!rst && psel && penable && pready === 1'b1 && !pwrite) begin
            if (expq.size() == 0) begin
                chk(32'h0000_0001, 32'h0000_0000);
            end else begin
                e = expq.pop_front();
                chk(prdata, e[31:0]);
                chk({31'h0, pslverr}, {31'h0, e[32]});
            end
        end
    end

    // ==========================================================
    // Drivers
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [32:0] e);
        int k;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        if (!wr) expq.push_back(e);
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin
            err_count++;
            end_sim;
        end
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic cmd(input logic [1:0] c);
        apb(1'b1, keying_pkg::CMD_OFS, {30'h0, c}, 33'h0);
        if (c[0]) to_f = 1'b0;
    endtask

    task automatic pin(input logic [6:0] p);
        @(posedge clk);
        lv <= p;
    endtask

    task automatic wk(input logic val, output int k);
        k = 0;
        while (key_o !== val && k < 200) begin
            @(negedge clk);
            k++;
        end
        if (k >= 200) begin
            err_count++;
            end_sim;
        end
    endtask

    // Pins pass a synchroniser and filter, so registered outputs lag a pin change by five edges, the merged request by four
    function automatic logic [8:0] exp_st(logic hk);
        logic m, d, f, r;
        m = lv[6] & lv[5];
        d = lv[1] ? lv[3] : lv[4];
        f = lv[0] ? ctrl[0] : ~lv[2];
        r = ctrl[1] ? ctrl[2] : (hdrv ? hbit : 1'b1);
        return {r, lv[2], f, d, ~m | hk, hk, to_f, ~m, m};
    endfunction

    task automatic look(input logic hk);
        logic [8:0] e;
        repeat (8) @(negedge clk);
        e = exp_st(hk);
        chk({27'h0, key_o, mrg_n, det_o, cps, css},
            {27'h0, e[4], e[0], e[5], e[5], ~e[5]});
        chk({31'h0, nfi}, {31'h0, e[6]});
        chk({30'h0, loe, ltx}, {30'h0, ctrl[1], ctrl[2]});
        apb(1'b0, keying_pkg::STATUS_OFS, 32'h0, {24'h0, e});
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk({26'h0, key_o, loe, nfi, css, cps, det_o}, 32'h0000_000C);
        apb(1'b0, keying_pkg::CTRL_OFS, 32'h0, {1'b0, keying_pkg::CTRL_RESET});
        apb(1'b1, keying_pkg::CTRL_OFS, 32'hFFFF_FFFF, 33'h0);
        apb(1'b0, keying_pkg::CTRL_OFS, 32'h0, 33'h0_0000_0007);
        apb(1'b0, 12'h010, 32'h0, 33'h1_0000_0000);
        apb(1'b1, keying_pkg::CTRL_OFS, 32'h0, 33'h0);
        $display("test registers done");
        for (int i = 0; i < 24; i++) begin
            v    = $random(seed);
            ctrl = v[9:7];
            // Host lets go of the pair before the block may take it
            hdrv <= 1'b0;
            apb(1'b1, keying_pkg::CTRL_OFS, {29'h0, ctrl}, 33'h0);
            @(posedge clk);
            hdrv <= v[10] & ~ctrl[1];
            hbit <= v[11];
            pin(v[6:0]);
            look(1'b0);
        end
        $display("test random pins done");
        pin(7'h00);
        look(1'b0);
        pin(7'h40);
        look(1'b0);
        pin(7'h60);
        look(1'b0);
        $display("test local keying done");
        cmd(2'b01);
        wk(1'b1, n);
        chk(32'(n <= 4), 32'h1);
        apb(1'b0, keying_pkg::TIMER_OFS, 32'h0, 33'h0_0000_0002);
        cmd(2'b10);
        wk(1'b0, n);
        chk(32'(n <= 4), 32'h1);
        look(1'b0);
        apb(1'b0, keying_pkg::TIMER_OFS, 32'h0, 33'h0_0000_0000);
        $display("test host release done");
        cmd(2'b01);
        repeat (30) @(negedge clk);
        cmd(2'b01);
        wk(1'b0, n);
        chk(32'(n >= TO - 4 && n <= TO + 3), 32'h1);
        to_f = 1'b1;
        look(1'b0);
        $display("test host timeout done");
        cmd(2'b01);
        wk(1'b1, n);
        pin(7'h20);
        repeat (8) @(negedge clk);
        cmd(2'b10);
        repeat (8) @(negedge clk);
        chk({31'h0, key_o}, 32'h1);
        pin(7'h60);
        wk(1'b0, n);
        chk(32'(n <= 10), 32'h1);
        look(1'b0);
        $display("test overlap done");
        end_sim;
    end
endmodule
